// [rtl/cjd_cond_eval.sv]
// condition evaluation for both conditional jumps
`timescale 1ns/100ps
module cjd_cond_eval (
  // start condition
  input wire logic [cjd_pkg::START_W-1:0] start_mask_field,
  input wire logic [cjd_pkg::START_W-1:0] start_latched,
  // status condition
  input wire logic [cjd_pkg::STATUS_W-1:0] core0_control_status,
  input wire logic [cjd_pkg::STATUS_W-1:0] core1_control_status,
  input wire logic core_id,
  input wire logic [3:0] status_bit_select,
  input wire logic polarity,
  // results
  output logic start_ok,
  output logic status_ok
);
  logic [cjd_pkg::STATUS_W-1:0] csr;
  always_comb begin
    // mask must match the latched starts exactly; zero means none latched
    start_ok = (start_latched == start_mask_field);
    csr = core_id ? core1_control_status : core0_control_status;
    status_ok = (csr[status_bit_select] == polarity);
  end
endmodule

// [rtl/cjd_decode.sv]
// decode and execute of two conditional jump instructions
// Functional notes
// - a taken start jump loads the counter with its own address plus offset.
// - the offset is a 5-bit two's complement value from -16 to +15.
// - the start jump is taken only when the selected start condition holds.
// - the 6-bit selector is a mask with bit n-1 for start n latched.
// - start jump opcode is bits 15:11 = 00001, mask 10:5, offset 4:0.
// - a taken status jump loads the counter from the chosen jump register.
// - the absolute target may be any code memory location.
// - a 4-bit selector picks status bit 0 to 15.
// - the tested bit comes from the core control and status registers.
// - polarity 0 tests for a low bit and 1 tests for a high bit.
// - status jump is 15:10 = 001111 and 3:0 = 0101, pol 9, sel 8:5, reg 4.
// - the tested register belongs to the microcore now executing.
`timescale 1ns/100ps
module cjd_decode (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [cjd_pkg::INSTR_W-1:0] instr,
  input wire logic core_id,
  // condition sources
  input wire logic [cjd_pkg::START_W-1:0] start_latched,
  input wire logic [cjd_pkg::STATUS_W-1:0] core0_control_status,
  input wire logic [cjd_pkg::STATUS_W-1:0] core1_control_status,
  // jump register set
  input wire logic [cjd_pkg::PC_W-1:0] jump_register_set_0,
  input wire logic [cjd_pkg::PC_W-1:0] jump_register_set_1,
  // program counter and status
  output logic [cjd_pkg::PC_W-1:0] program_counter,
  output logic jump_taken,
  output logic jump_decoded
);
  typedef enum logic [2:0] {
    ST_OTHER = 3'h1,
    ST_JREL = 3'h2,
    ST_JSTAT = 3'h4
  } cjd_kind_type;

  function automatic logic [cjd_pkg::PC_W-1:0] sext_offs(
    input logic [cjd_pkg::OFFS_W-1:0] offs);
    sext_offs = {{(cjd_pkg::PC_W-cjd_pkg::OFFS_W){offs[cjd_pkg::OFFS_W-1]}},
                 offs};
  endfunction

  cjd_kind_type kind;
  logic start_ok;
  logic status_ok;
  logic [cjd_pkg::PC_W-1:0] pc_ff, nxt_pc;
  logic taken_ff, nxt_taken;
  logic dec_ff, nxt_dec;

  cjd_cond_eval u_cond (
    .start_mask_field(instr[cjd_pkg::JREL_MASK_HI:cjd_pkg::JREL_MASK_LO]),
    .start_latched(start_latched),
    .core0_control_status(core0_control_status),
    .core1_control_status(core1_control_status),
    .core_id(core_id),
    .status_bit_select(instr[cjd_pkg::JSTAT_SEL_HI:cjd_pkg::JSTAT_SEL_LO]),
    .polarity(instr[cjd_pkg::JSTAT_POL_BIT]),
    .start_ok(start_ok),
    .status_ok(status_ok)
  );

  always_comb begin
    kind = ST_OTHER;
    if (instr[cjd_pkg::JREL_OP_HI:cjd_pkg::JREL_OP_LO]
        == cjd_pkg::JREL_OPCODE) begin
      kind = ST_JREL;
    end else if ((instr[cjd_pkg::JSTAT_OP_HI:cjd_pkg::JSTAT_OP_LO]
                  == cjd_pkg::JSTAT_OPCODE) &&
                 (instr[cjd_pkg::JSTAT_SUB_HI:cjd_pkg::JSTAT_SUB_LO]
                  == cjd_pkg::JSTAT_SUBCODE)) begin
      kind = ST_JSTAT;
    end
  end

  always_comb begin
    nxt_pc = pc_ff;
    nxt_taken = 1'b0;
    nxt_dec = 1'b0;
    if (instr_valid) begin
      // default path also covers instructions decoded elsewhere
      nxt_pc = pc_ff + cjd_pkg::PC_STEP;
      case (kind)
        ST_JREL: begin
          nxt_dec = 1'b1;
          if (start_ok) begin
            // wraps modulo code size, as the counter does
            nxt_pc = pc_ff + sext_offs(
              instr[cjd_pkg::JREL_OFFS_HI:cjd_pkg::JREL_OFFS_LO]);
            nxt_taken = 1'b1;
          end
        end
        ST_JSTAT: begin
          nxt_dec = 1'b1;
          if (status_ok) begin
            nxt_pc = instr[cjd_pkg::JSTAT_REG_BIT] ? jump_register_set_1
                                                   : jump_register_set_0;
            nxt_taken = 1'b1;
          end
        end
        default: begin
          nxt_dec = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_ff <= cjd_pkg::PC_RESET;
      taken_ff <= 1'b0;
      dec_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      taken_ff <= nxt_taken;
      dec_ff <= nxt_dec;
    end
  end

  assign program_counter = pc_ff;
  assign jump_taken = taken_ff;
  assign jump_decoded = dec_ff;
endmodule

// [rtl/cjd_pkg.sv]
// package of constants for the conditional jump decoder
package cjd_pkg;
  localparam int PC_W = 10;
  localparam int INSTR_W = 16;
  localparam int START_W = 6;
  localparam int STATUS_W = 16;
  localparam int OFFS_W = 5;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  // start-conditioned relative jump
  localparam int JREL_OP_HI = 15;
  localparam int JREL_OP_LO = 11;
  localparam logic [4:0] JREL_OPCODE = 5'h01;
  localparam int JREL_MASK_HI = 10;
  localparam int JREL_MASK_LO = 5;
  localparam int JREL_OFFS_HI = 4;
  localparam int JREL_OFFS_LO = 0;
  // status-bit absolute jump
  localparam int JSTAT_OP_HI = 15;
  localparam int JSTAT_OP_LO = 10;
  localparam logic [5:0] JSTAT_OPCODE = 6'h0F;
  localparam int JSTAT_SUB_HI = 3;
  localparam int JSTAT_SUB_LO = 0;
  localparam logic [3:0] JSTAT_SUBCODE = 4'h5;
  localparam int JSTAT_POL_BIT = 9;
  localparam int JSTAT_SEL_HI = 8;
  localparam int JSTAT_SEL_LO = 5;
  localparam int JSTAT_REG_BIT = 4;
  // control and status register addresses of the two microcores
  localparam logic [8:0] CORE0_CSR_A = 9'h101;
  localparam logic [8:0] CORE0_CSR_B = 9'h102;
  localparam logic [8:0] CORE1_CSR_A = 9'h121;
  localparam logic [8:0] CORE1_CSR_B = 9'h122;
endpackage

// [verification/cjd_decode_bench.sv]
// self-checking bench for the conditional jump decoder
`timescale 1ns/100ps
module cjd_decode_bench;
  logic clk, rst_n, instr_valid, core_id, t, jump_taken, jump_decoded;
  logic [15:0] instr, c0, c1;
  logic [5:0] sl;
  logic [9:0] j0, j1, pcm, nx, program_counter;
  logic [11:0] note_q[$];
  int n_mismatch = 0, comparisons = 0, k;
  cjd_decode uut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .core_id(core_id), .start_latched(sl),
    .core0_control_status(c0), .core1_control_status(c1),
    .jump_register_set_0(j0), .jump_register_set_1(j1),
    .program_counter(program_counter), .jump_taken(jump_taken),
    .jump_decoded(jump_decoded));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one instruction per cycle, back to back; idle cycles mixed in
  task step(input int kind);
    {instr, c0, c1, j0, j1} = {$urandom, $urandom, $urandom};
    {core_id, sl} = 7'($urandom);
    instr_valid = (kind != 3);
    t = 1'b0;
    if (kind == 0) begin
      instr[15:11] = 5'h01;
      if ($urandom % 2) sl = instr[10:5];
      t = (sl == instr[10:5]);
      nx = pcm + {{5{instr[4]}}, instr[4:0]};
    end else if (kind == 1) begin
      instr[15:10] = 6'h0F;
      instr[3:0] = 4'h5;
      t = (core_id ? c1[instr[8:5]] : c0[instr[8:5]]) == instr[9];
      nx = instr[4] ? j1 : j0;
    end else if (instr[15:11] == 5'h01 || instr[15:10] == 6'h0F) begin
      instr[15] = 1'b1;
    end
    if (kind == 3) note_q.push_back({pcm, 2'b00});
    else if (t) note_q.push_back({nx, 2'b11});
    else note_q.push_back({pcm + 10'h001, 1'b0, 1'(kind < 2)});
    pcm = note_q[$][11:2];
  endtask
  always @(posedge clk) begin
    #1;
    if (note_q.size() > 0)
      chk(note_q.pop_front(), {program_counter, jump_taken, jump_decoded});
  end
  initial begin
    {rst_n, instr_valid, core_id, instr, c0, c1, sl, j0, j1} = '0;
    pcm = 10'h000;
    void'($urandom(32'h137c));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 600; k++) begin
      step($urandom % 4);
      @(negedge clk);
    end
    $display("test random jumps done");
    rst_n = 1'b0;
    note_q.push_back(12'h000);
    pcm = 10'h000;
    @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 100; k++) begin
      step($urandom % 4);
      @(negedge clk);
    end
    $display("test mid-run reset done");
    print_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
endmodule

// [verification/cjd_decode_sva.sv]
// assertions for the conditional jump decoder
`timescale 1ns/100ps
module cjd_decode_sva (
  input wire logic clk, rst_n, instr_valid, core_id,
  input wire logic [15:0] instr, core0_control_status, core1_control_status,
  input wire logic [5:0] start_latched,
  input wire logic [9:0] jump_register_set_0, jump_register_set_1,
  input wire logic [9:0] program_counter,
  input wire logic jump_taken, jump_decoded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rel = instr_valid && instr[15:11] == 5'h01;
  wire stat = instr_valid && instr[15:10] == 6'h0F && instr[3:0] == 4'h5;
  wire [15:0] csr = core_id ? core1_control_status : core0_control_status;
  wire s_ok = csr[instr[8:5]] == instr[9];
  wire m_ok = start_latched == instr[10:5];
  wire [9:0] jreg = instr[4] ? jump_register_set_1 : jump_register_set_0;
  wire [9:0] tgt = program_counter + {{5{instr[4]}}, instr[4:0]};
  sequence s_step;
    !jump_taken && program_counter == $past(program_counter) + 10'h001;
  endsequence
  a_rel_jump: assert property (rel && m_ok |=>
    jump_taken && program_counter == $past(tgt)) else $error("rel jump");
  a_rel_hold: assert property (rel && !m_ok |=>
    s_step ##0 jump_decoded) else $error("rel not taken");
  a_stat_jump: assert property (stat && s_ok |=>
    jump_taken && program_counter == $past(jreg)) else $error("stat jump");
  a_stat_hold: assert property (stat && !s_ok |=>
    s_step ##0 jump_decoded) else $error("stat not taken");
  a_other_step: assert property (instr_valid && !rel && !stat |=>
    s_step ##0 !jump_decoded) else $error("other opcode");
  a_idle_hold: assert property (!instr_valid |=>
    $stable(program_counter) && !jump_taken) else $error("idle moved");
  a_decode_flag: assert property (rel || stat |=>
    jump_decoded) else $error("decode flag");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
    program_counter == 10'h000 && !jump_taken) else $error("reset");
endmodule
bind cjd_decode cjd_decode_sva u_sva (.clk, .rst_n, .instr_valid, .core_id,
  .instr, .core0_control_status, .core1_control_status, .start_latched,
  .jump_register_set_0, .jump_register_set_1, .program_counter,
  .jump_taken, .jump_decoded);
